// [src/pmcs_phy_mgmt.v]
`timescale 1ns/100ps
`include "pmcs_map.vh"

module pmcs_phy_mgmt #(
  parameter [23:0] OUI      = 24'h5A3C96,  // Arbitrary neutral value.
  parameter [5:0]  MODEL    = 6'h2A,       // Arbitrary neutral value.
  parameter [3:0]  REVISION = 4'h3         // Arbitrary neutral value.
) (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        rstn,
  // Management bus pins.
  input  wire        mdc,
  input  wire        mdioIn,
  output reg         mdioOut,
  output reg         mdioOe,
  input  wire [4:0]  phyAddr,
  // Line conditions from the transceiver core.
  input  wire        anComplete,
  input  wire        remoteFault,
  input  wire        jabberDetect,
  input  wire        linkUp,
  // Control outputs to the transceiver core.
  output reg         softReset,
  output reg         loopback,
  output reg         speed100,
  output reg         anEnable,
  output reg         lowPower,
  output reg         isolate,
  output reg         anRestart,
  output reg         fullDuplex,
  output reg         collisionTest
);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame engine states, one hot.
  localparam [4:0] S_PRE   = 5'b00001;
  localparam [4:0] S_START = 5'b00010;
  localparam [4:0] S_HDR   = 5'b00100;
  localparam [4:0] S_TA    = 5'b01000;
  localparam [4:0] S_DATA  = 5'b10000;

  localparam integer SRST_CYCLES_INT = `PMCS_SRST_CYCLES;
  localparam [7:0]   SRST_CYCLES     = SRST_CYCLES_INT[7:0];

  // Picks count identifier bits starting at base, first bit into bit 15.
  function [15:0] ouiSlice;
    input [23:0] oui;
    input integer base;
    input integer count;
    integer i;
    begin
      ouiSlice = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        if (i < count) begin
          ouiSlice[15 - i] = oui[base + i];
        end
      end
    end
  endfunction

  // Reset value of one control field, taken from the control word default.
  function ctlDefault;
    input integer pos;
    reg [15:0] dflt;
    begin
      dflt       = `PMCS_CTL_RESET_VAL;
      ctlDefault = dflt[pos];
    end
  endfunction

  // True for the two opcodes that the frame engine answers.
  function isAccessOp;
    input [1:0] op;
    begin
      isAccessOp = (op == `PMCS_OP_READ) || (op == `PMCS_OP_WRITE);
    end
  endfunction

  // Places a latched flag at its bit position of the status word.
  function [15:0] placeFlag;
    input         flag;
    input integer pos;
    begin
      placeFlag      = 16'h0000;
      placeFlag[pos] = flag;
    end
  endfunction

  // Identifier bit n sits at vector index n-1.
  localparam [15:0] ID_HIGH     = ouiSlice(OUI, 2, 16);
  localparam [15:0] ID_LOW_OUI  = ouiSlice(OUI, 18, 6);
  localparam [15:0] ID_LOW      = {ID_LOW_OUI[15:10], MODEL, REVISION};

  ////////////////////////////////////////////////////////////////////////////////
  reg        mdcS1;
  reg        mdcS2;
  reg        mdcS3;
  reg        mdioS1;
  reg        mdioS2;
  reg  [4:0] addrS1;
  reg  [4:0] addrS2;
  wire       mdcRise;

  reg  [4:0]  state;
  reg  [5:0]  preCnt;
  reg  [4:0]  bitCnt;
  reg  [11:0] hdr;
  reg         isRead;
  reg         hit;
  reg  [15:0] shift;
  reg         wrStrobe;
  reg  [15:0] wrData;
  reg         stsRead;
  reg  [7:0]  srstCnt;
  reg  [15:0] advertise;

  reg         anLat;
  reg         faultLat;
  reg         jabLat;
  reg         linkLat;

  wire [11:0] hdrFull;
  wire [4:0]  regAddr;
  wire [15:0] ctrlWord;
  wire [15:0] statusWord;
  reg  [15:0] readValue;

  // The pins are sampled on the system clock, so each mdc phase must last at least
  // one clock period; a shorter phase can fall between two clock edges and be missed altogether.
  // Logic takes the second stage of each synchroniser, and mdcS3 as well for the mdc edge detect.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      mdcS1  <= 1'b0;
      mdcS2  <= 1'b0;
      mdcS3  <= 1'b0;
      mdioS1 <= 1'b1;
      mdioS2 <= 1'b1;
      addrS1 <= 5'h00;
      addrS2 <= 5'h00;
    end else begin
      mdcS1  <= mdc;
      mdcS2  <= mdcS1;
      mdcS3  <= mdcS2;
      mdioS1 <= mdioIn;
      mdioS2 <= mdioS1;
      addrS1 <= phyAddr;
      addrS2 <= addrS1;
    end
  end

  // Frame bits are taken on the rising edge of the synchronised management clock.
  assign mdcRise = mdcS2 & ~mdcS3;
  assign hdrFull = {hdr[10:0], mdioS2};
  assign regAddr = hdr[4:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Read data assembly.
  assign ctrlWord = {softReset, loopback, speed100, anEnable, lowPower, isolate,
                     anRestart, fullDuplex, collisionTest, 7'h00};
  assign statusWord = `PMCS_STS_CONST_VAL
                    | placeFlag(anLat,    `PMCS_STS_AN_DONE)
                    | placeFlag(faultLat, `PMCS_STS_REM_FAULT)
                    | placeFlag(linkLat,  `PMCS_STS_LINK)
                    | placeFlag(jabLat,   `PMCS_STS_JABBER);

  // Registers outside the decoded set read as zero and ignore writes.
  always @* begin
    case (regAddr)
      `PMCS_REG_CONTROL:   readValue = ctrlWord;
      `PMCS_REG_STATUS:    readValue = statusWord;
      `PMCS_REG_ID_HIGH:   readValue = ID_HIGH;
      `PMCS_REG_ID_LOW:    readValue = ID_LOW;
      `PMCS_REG_ADVERTISE: readValue = advertise;
      default:             readValue = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Management frame engine: preamble, start, header, turnaround, data.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      state    <= S_PRE;
      preCnt   <= 6'h00;
      bitCnt   <= 5'h00;
      hdr      <= 12'h000;
      isRead   <= 1'b0;
      hit      <= 1'b0;
      shift    <= 16'h0000;
      mdioOut  <= 1'b0;
      mdioOe   <= 1'b0;
      wrStrobe <= 1'b0;
      wrData   <= 16'h0000;
      stsRead  <= 1'b0;
    end else begin
      // Both strobes last one clock.
      wrStrobe <= 1'b0;
      stsRead  <= 1'b0;
      if (mdcRise) begin
        case (state)
          S_PRE: begin
            if (mdioS2) begin
              if (preCnt != `PMCS_PREAMBLE_BITS) begin
                preCnt <= preCnt + 6'h01;
              end
            end else if (preCnt == `PMCS_PREAMBLE_BITS) begin
              state <= S_START;
            end else begin
              preCnt <= 6'h00;
            end
          end
          S_START: begin
            bitCnt <= 5'h00;
            preCnt <= 6'h00;
            if (mdioS2) begin
              state <= S_HDR;
            end else begin
              state <= S_PRE;
            end
          end
          S_HDR: begin
            hdr    <= hdrFull;
            bitCnt <= bitCnt + 5'h01;
            if (bitCnt == `PMCS_HDR_LAST) begin
              isRead <= (hdrFull[11:10] == `PMCS_OP_READ);
              hit    <= (hdrFull[9:5] == addrS2) && isAccessOp(hdrFull[11:10]);
              bitCnt <= 5'h00;
              state  <= S_TA;
            end
          end
          // The line is taken low on the first turnaround bit, data follows the second.
          S_TA: begin
            if (bitCnt == 5'h00) begin
              bitCnt <= 5'h01;
              if (hit && isRead) begin
                mdioOe  <= 1'b1;
                mdioOut <= 1'b0;
              end
            end else begin
              bitCnt <= 5'h00;
              state  <= S_DATA;
              if (hit && isRead) begin
                mdioOut <= readValue[15];
                shift   <= {readValue[14:0], 1'b0};
                stsRead <= (regAddr == `PMCS_REG_STATUS);
              end
            end
          end
          S_DATA: begin
            bitCnt <= bitCnt + 5'h01;
            if (isRead) begin
              mdioOut <= shift[15];
              shift   <= {shift[14:0], 1'b0};
            end else begin
              shift <= {shift[14:0], mdioS2};
            end
            // A frame cut short waits here; later mdc edges complete the count, so a partial word can still be written.
            if (bitCnt == `PMCS_DATA_LAST) begin
              mdioOe   <= 1'b0;
              mdioOut  <= 1'b0;
              wrStrobe <= hit & ~isRead;
              wrData   <= {shift[14:0], mdioS2};
              preCnt   <= 6'h00;
              bitCnt   <= 5'h00;
              state    <= S_PRE;
            end
          end
          default: begin
            state  <= S_PRE;
            preCnt <= 6'h00;
            mdioOe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, advertisement and latched status registers.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      softReset     <= 1'b0;
      srstCnt       <= 8'h00;
      loopback      <= 1'b0;
      speed100      <= 1'b1;
      anEnable      <= 1'b1;
      lowPower      <= 1'b0;
      isolate       <= 1'b0;
      anRestart     <= 1'b0;
      fullDuplex    <= 1'b1;
      collisionTest <= 1'b0;
      advertise     <= `PMCS_ADV_RESET_VAL;
      anLat         <= 1'b0;
      faultLat      <= 1'b0;
      jabLat        <= 1'b0;
      linkLat       <= 1'b0;
    end else begin
      anRestart <= 1'b0;
      if (softReset) begin
        // Hold every control field at its default until the reset ends.
        // The latches restart too, so link reads down until the next status read.
        srstCnt       <= srstCnt - 8'h01;
        softReset     <= (srstCnt != 8'h01);
        loopback      <= ctlDefault(`PMCS_CTL_LOOPBACK);
        speed100      <= ctlDefault(`PMCS_CTL_SPEED);
        anEnable      <= ctlDefault(`PMCS_CTL_AN_ENABLE);
        lowPower      <= ctlDefault(`PMCS_CTL_LOW_POWER);
        isolate       <= ctlDefault(`PMCS_CTL_ISOLATE);
        fullDuplex    <= ctlDefault(`PMCS_CTL_DUPLEX);
        collisionTest <= ctlDefault(`PMCS_CTL_COL_TEST);
        advertise     <= `PMCS_ADV_RESET_VAL;
        anLat         <= 1'b0;
        faultLat      <= 1'b0;
        jabLat        <= 1'b0;
        linkLat       <= 1'b0;
      end else begin
        if (wrStrobe && (regAddr == `PMCS_REG_CONTROL)) begin
          if (wrData[`PMCS_CTL_RESET]) begin
            softReset <= 1'b1;
            srstCnt   <= SRST_CYCLES;
          end else begin
            loopback      <= wrData[`PMCS_CTL_LOOPBACK];
            speed100      <= wrData[`PMCS_CTL_SPEED];
            anEnable      <= wrData[`PMCS_CTL_AN_ENABLE];
            lowPower      <= wrData[`PMCS_CTL_LOW_POWER];
            isolate       <= wrData[`PMCS_CTL_ISOLATE];
            anRestart     <= wrData[`PMCS_CTL_AN_RESTART];
            fullDuplex    <= wrData[`PMCS_CTL_DUPLEX];
            collisionTest <= wrData[`PMCS_CTL_COL_TEST];
          end
        end
        // Only the ability, remote fault and next page bits take written values.
        if (wrStrobe && (regAddr == `PMCS_REG_ADVERTISE)) begin
          advertise <= (wrData & `PMCS_ADV_WRITE_MASK) |
                       (`PMCS_ADV_RESET_VAL & ~`PMCS_ADV_WRITE_MASK);
        end
        // A read hands out the held value, then the flags restart from now.
        if (stsRead) begin
          anLat    <= anComplete;
          faultLat <= remoteFault;
          jabLat   <= jabberDetect;
          linkLat  <= linkUp;
        end else begin
          anLat    <= anLat | anComplete;
          faultLat <= faultLat | remoteFault;
          jabLat   <= jabLat | jabberDetect;
          linkLat  <= linkLat & linkUp;
        end
      end
    end
  end

endmodule // pmcs_phy_mgmt

// [src/pmcs_map.vh]
`ifndef PMCS_MAP_VH
`define PMCS_MAP_VH

// Register addresses on the management bus.
`define PMCS_REG_CONTROL      5'h00
`define PMCS_REG_STATUS       5'h01
`define PMCS_REG_ID_HIGH      5'h02
`define PMCS_REG_ID_LOW       5'h03
`define PMCS_REG_ADVERTISE    5'h04
`define PMCS_REG_PARTNER      5'h05
`define PMCS_REG_EXPANSION    5'h06
`define PMCS_REG_NP_TRANSMIT  5'h07
`define PMCS_REG_NP_PARTNER   5'h08
`define PMCS_REG_RSVD_FIRST   5'h09
`define PMCS_REG_VENDOR_FIRST 5'h10

// Control register bit positions.
`define PMCS_CTL_RESET        15
`define PMCS_CTL_LOOPBACK     14
`define PMCS_CTL_SPEED        13
`define PMCS_CTL_AN_ENABLE    12
`define PMCS_CTL_LOW_POWER    11
`define PMCS_CTL_ISOLATE      10
`define PMCS_CTL_AN_RESTART   9
`define PMCS_CTL_DUPLEX       8
`define PMCS_CTL_COL_TEST     7

// Status register bit positions of the latched flags.
`define PMCS_STS_AN_DONE      5
`define PMCS_STS_REM_FAULT    4
`define PMCS_STS_LINK         2
`define PMCS_STS_JABBER       1

// Reset and constant values.
`define PMCS_CTL_RESET_VAL    16'h3100
`define PMCS_STS_CONST_VAL    16'h7809
`define PMCS_ADV_RESET_VAL    16'h01E1
`define PMCS_ADV_WRITE_MASK   16'hA1E0

// Management frame fields.
`define PMCS_PREAMBLE_BITS    6'h20
`define PMCS_OP_READ          2'b10
`define PMCS_OP_WRITE         2'b01
`define PMCS_HDR_LAST         5'h0B
`define PMCS_DATA_LAST        5'h0F

// Timing.
`define PMCS_CLK_PERIOD_NS    40
`define PMCS_SRST_TIME_NS     640
`define PMCS_SRST_CYCLES \
  ((`PMCS_SRST_TIME_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS)

`endif

// [sim/pmcs_phy_mgmt_monitor.sv]
`timescale 1ns/100ps
`include "pmcs_map.vh"
module pmcs_phy_mgmt_monitor (
  // Clock, reset and bus pins.
  input logic       clk_sys,
  input logic       rstn,
  input logic       mdc,
  input logic       mdioIn,
  input logic       mdioOut,
  input logic       mdioOe,
  input logic [4:0] phyAddr,
  // Line conditions.
  input logic       anComplete,
  input logic       remoteFault,
  input logic       jabberDetect,
  input logic       linkUp,
  // Control outputs.
  input logic       softReset,
  input logic       loopback,
  input logic       speed100,
  input logic       anEnable,
  input logic       lowPower,
  input logic       isolate,
  input logic       anRestart,
  input logic       fullDuplex,
  input logic       collisionTest
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [5:0] srCnt;
  always @(posedge clk_sys) begin
    srCnt <= (!rstn || !softReset) ? 6'h00 : srCnt + 6'h01;
  end
  a_restart_single: assert property (anRestart |=> !anRestart)
    else $error("restart pulse longer than one cycle");
  a_restart_quiet_srst: assert property (softReset |-> !anRestart)
    else $error("restart pulse during soft reset");
  a_srst_length: assert property ($fell(softReset) |-> srCnt == `PMCS_SRST_CYCLES)
    else $error("soft reset length wrong");
  a_srst_defaults: assert property (softReset |=> speed100 && anEnable && fullDuplex
    && !loopback && !lowPower && !isolate && !collisionTest)
    else $error("control fields not at defaults in soft reset");
  a_srst_no_drive: assert property ($rose(softReset) |-> !mdioOe)
    else $error("soft reset started while driving");
  a_ctl_quiet_drive: assert property ($changed({loopback, speed100, anEnable, lowPower,
    isolate, fullDuplex, collisionTest}) |-> !mdioOe)
    else $error("control changed during a read");
  a_turn_zero: assert property ($rose(mdioOe) |-> !mdioOut)
    else $error("turnaround bit not zero");
  a_drive_stands: assert property ($rose(mdioOe) |=> mdioOe [*8])
    else $error("read drive too short");
endmodule // pmcs_phy_mgmt_monitor
bind pmcs_phy_mgmt pmcs_phy_mgmt_monitor i_mon (.clk_sys, .rstn, .mdc, .mdioIn, .mdioOut,
  .mdioOe, .phyAddr, .anComplete, .remoteFault, .jabberDetect, .linkUp, .softReset,
  .loopback, .speed100, .anEnable, .lowPower, .isolate, .anRestart, .fullDuplex,
  .collisionTest);

// [sim/pmcs_sta_model.sv]
`timescale 1ns/100ps
module pmcs_sta_model (
  // Clock and bus pins.
  input  logic clk_sys,
  input  logic mdio,
  output logic mdc,
  output logic staOut,
  output logic staOe
);
  initial begin
    mdc = 1'b0;
    staOut = 1'b1;
    staOe = 1'b0;
  end
  // The clock stands low between frames, and a released line floats to the pull-up.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, input int pre, output logic [15:0] rd);
    logic [31:0] tail;
    tail = {2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < pre + 32; i++) begin
      @(posedge clk_sys);
      staOe <= !(op == 2'b10 && i >= pre + 14);
      staOut <= (i < pre) ? 1'b1 : tail[pre + 31 - i];
      repeat (4) @(posedge clk_sys);
      if (i >= pre + 16) rd = {rd[14:0], mdio};
      mdc <= 1'b1;
      repeat (4) @(posedge clk_sys);
      mdc <= 1'b0;
    end
    @(posedge clk_sys);
    staOe <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // pmcs_sta_model

// [sim/tb_top.sv]
`timescale 1ns/100ps
`include "pmcs_map.vh"
module tb_top;
  localparam logic [23:0] OUI_VAL = 24'h5A3C96;  // Arbitrary value.
  localparam logic [4:0]  ADDR    = 5'h11;
  localparam logic [5:0]  MODEL_VAL = 6'h2A;  // Arbitrary value.
  localparam logic [3:0]  REV_VAL   = 4'h3;   // Arbitrary value.
  logic clk_sys, rstn, mdc, staOut, staOe, mdioOut, mdioOe, anComplete, remoteFault;
  logic jabberDetect, linkUp, softReset, loopback, speed100, anEnable, lowPower;
  logic isolate, anRestart, fullDuplex, collisionTest;
  logic [15:0] rd;
  int          failures = 0, checks = 0, pulses = 0, oeCnt = 0, srRun = 0, srLen = 0;
  wire         mdio = mdioOe ? mdioOut : (staOe ? staOut : 1'b1);
  pmcs_phy_mgmt #(.OUI(OUI_VAL), .MODEL(MODEL_VAL), .REVISION(REV_VAL)) i_dut (.clk_sys,
    .rstn, .mdc, .mdioIn(mdio), .mdioOut, .mdioOe, .phyAddr(ADDR), .anComplete,
    .remoteFault, .jabberDetect, .linkUp, .softReset, .loopback, .speed100, .anEnable,
    .lowPower, .isolate, .anRestart, .fullDuplex, .collisionTest);
  pmcs_sta_model i_sta (.clk_sys, .mdio, .mdc, .staOut, .staOe);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    pulses <= pulses + (anRestart === 1'b1);
    oeCnt <= oeCnt + (mdioOe === 1'b1);
    srRun <= (softReset === 1'b1) ? srRun + 1 : 0;
    if (softReset !== 1'b1 && srRun != 0) srLen <= srRun;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [15:0] outs();
    return {7'h00, loopback, speed100, anEnable, lowPower, isolate, fullDuplex,
            collisionTest, softReset, anRestart};
  endfunction
  task automatic rd_reg(input logic [4:0] ra);
    i_sta.frame(2'b10, ADDR, ra, 16'h0000, 32, rd);
  endtask
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] v);
    logic [15:0] unused;
    i_sta.frame(2'b01, ADDR, ra, v, 32, unused);
  endtask
  task automatic t_defaults();
    logic [15:0] idExp;
    for (int i = 0; i < 16; i++) idExp[15 - i] = OUI_VAL[2 + i];
    check("outputs", 16'h00C8, outs());
    rd_reg(`PMCS_REG_CONTROL);
    check("control", 16'h3100, rd);
    rd_reg(`PMCS_REG_STATUS);
    check("status", 16'h7809, rd);
    wr_reg(`PMCS_REG_ID_HIGH, 16'hFFFF);
    rd_reg(`PMCS_REG_ID_HIGH);
    check("id high", idExp, rd);
    rd_reg(`PMCS_REG_ID_LOW);
    check("id low", 16'h6AA3, rd);
  endtask
  task automatic t_control();
    wr_reg(`PMCS_REG_CONTROL, 16'h5CFF);
    check("outputs", 16'h0174, outs());
    rd_reg(`PMCS_REG_CONTROL);
    check("control", 16'h5C80, rd);
    wr_reg(`PMCS_REG_CONTROL, 16'h2100);
    check("outputs", 16'h0088, outs());
    rd_reg(`PMCS_REG_CONTROL);
    check("control", 16'h2100, rd);
    rd_reg(`PMCS_REG_ADVERTISE);
    check("advertise", 16'h01E1, rd);
    wr_reg(`PMCS_REG_ADVERTISE, 16'hFFFF);
    rd_reg(`PMCS_REG_ADVERTISE);
    check("advertise", 16'hA1E1, rd);
  endtask
  task automatic t_resets();
    int p0;
    p0 = pulses;
    wr_reg(`PMCS_REG_CONTROL, 16'h3300);
    check("restart pulses", 16'h0001, 16'(pulses - p0));
    rd_reg(`PMCS_REG_CONTROL);
    check("control", 16'h3100, rd);
    wr_reg(`PMCS_REG_CONTROL, 16'h6000);
    wr_reg(`PMCS_REG_CONTROL, 16'h8000);
    for (int i = 0; i < 100 && srLen == 0; i++) @(posedge clk_sys);
    check("reset length", 16'(`PMCS_SRST_CYCLES), 16'(srLen));
    rd_reg(`PMCS_REG_CONTROL);
    check("control", 16'h3100, rd);
    rd_reg(`PMCS_REG_ADVERTISE);
    check("advertise", 16'h01E1, rd);
  endtask
  task automatic t_latch();
    @(posedge clk_sys);
    {anComplete, remoteFault, jabberDetect, linkUp} <= 4'hF;
    repeat (2) @(posedge clk_sys);
    {anComplete, remoteFault, jabberDetect} <= 3'h0;
    rd_reg(`PMCS_REG_STATUS);
    check("status", 16'h783B, rd);
    rd_reg(`PMCS_REG_STATUS);
    check("status", 16'h780D, rd);
    linkUp <= 1'b0;
    repeat (2) @(posedge clk_sys);
    linkUp <= 1'b1;
    rd_reg(`PMCS_REG_STATUS);
    check("status", 16'h7809, rd);
    rd_reg(`PMCS_REG_STATUS);
    check("status", 16'h780D, rd);
  endtask
  task automatic t_refused();
    int o0;
    i_sta.frame(2'b01, ADDR ^ 5'h01, 5'h00, 16'h4000, 32, rd);
    i_sta.frame(2'b01, ADDR, 5'h00, 16'h4000, 31, rd);
    i_sta.frame(2'b11, ADDR, 5'h00, 16'h4000, 32, rd);
    o0 = oeCnt;
    i_sta.frame(2'b10, ADDR ^ 5'h01, 5'h00, 16'h0000, 32, rd);
    check("drive count", 16'h0000, 16'(oeCnt - o0));
    rd_reg(`PMCS_REG_CONTROL);
    check("control", 16'h3100, rd);
    wr_reg(5'h09, 16'hFFFF);
    for (int a = 9; a < 32; a += 7) begin
      rd_reg(5'(a));
      check("unmapped", 16'h0000, rd);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, anComplete, remoteFault, jabberDetect, linkUp} <= 5'h00;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_defaults();
    t_control();
    t_resets();
    t_latch();
    t_refused();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    conclude();
  end
endmodule // tb_top
